/* File: logic/rtb_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtb_defs.svh"

// Behaviour
// R1: Offset estimate read-only, 8-bit signed
// R2: One estimate step equals 7800 Hz
// R3: Mode 0 freezes after sync until frame end
// R4: Mode 1: update while demodulator enabled
// R5: Buffer current follows TX or RX field
// R6: Override bit applies software capacitor value
// R7: Calibration loads capacitor field; read shows effective
// R8: Varactor DAC enabled only while bit set
// R9: 4-bit varactor code drives DAC
// R10: Calibration lasts 80/100/125/250 crystal periods
// R11: Extension bit gates anti-alias gain adjustment
// R12: Extra attenuation when error exceeds threshold
// R13: Software keeps threshold above 0x0C
// R14: Larger mixer code means larger current
// R15: Reserved top bits read zero, ignore writes; VCO current register stores its upper bits as written
// R16: Reset restores fields; fields hold until changed
module rtb_bank (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,

    // Radio state
    input  wire rtb_pkg::rtb_demod_s    demod,
    input  wire logic                   tx_active,

    // Calibration
    input  wire logic                   cal_start,
    input  wire logic                   crystal_osc_tick,
    input  wire logic [5:0]             cal_result,
    output logic                        cal_busy,

    // AGC
    input  wire logic [5:0]             agc_error_db,

    // Front-end controls
    output rtb_pkg::rtb_frontend_s      frontend
);
    import rtb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    // One byte each, reserved bits masked except in VCO current

    logic [7:0]  freq_offset_estimate;  // Signed estimate
    logic [7:0]  receive_tuning;        // Bias and mixer
    logic [7:0]  synth_tuning;          // Divider currents
    logic [7:0]  vco_current_tuning;    // VCO core current
    logic [7:0]  cap_array_control;     // Override and setting
    logic [7:0]  varactor_cal_control;  // DAC and accuracy
    logic [7:0]  agc_range_control;     // Extension control
    logic [7:0]  demod_control;         // Averaging mode
    logic        est_frozen;            // Sync seen; used by mode 0

    rtb_cal_e    cal_state;             // Calibration state
    logic [7:0]  cal_count;             // Crystal periods seen
    logic [7:0]  cal_len;               // Periods for this run
    logic        cal_done;              // Last period reached

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    // Word index; bad addresses refused

    logic        acc_phase;             // Access phase
    logic        wr_fire;               // Write takes effect
    logic [16:0] idx;                   // Register index
    logic        idx_hit;               // Mapped register
    logic        idx_ro;                // Read-only register
    logic        addr_ok;               // Aligned, in range
    logic [7:0]  rd_mux;                // Read data
    logic [7:0]  wdat;                  // Low write byte

    assign acc_phase = psel & penable;
    assign idx       = paddr[18:2];
    assign addr_ok   = (paddr[1:0] == 2'h0) && (paddr[31:19] == 13'h0000);
    assign idx_ro    = (idx == `RTB_IDX_FREQ_EST);
    assign wdat      = pwdata[7:0];
    assign wr_fire   = acc_phase & pready & pwrite & ~pslverr;

    // Index decode and read mux; masked reserved bits read zero
    always_comb begin
        // Mapped, reads zero
        idx_hit = 1'b1;
        rd_mux  = 8'h00;
        case (idx)
            `RTB_IDX_FREQ_EST:   rd_mux = freq_offset_estimate;  // see R1
            `RTB_IDX_RX_TUNE:    rd_mux = receive_tuning;
            `RTB_IDX_SYNTH_TUNE: rd_mux = synth_tuning;
            `RTB_IDX_VCO_CURR:   rd_mux = vco_current_tuning;
            `RTB_IDX_CAP_ARRAY:  rd_mux = cap_array_control;     // see R7
            `RTB_IDX_VARACTOR:   rd_mux = varactor_cal_control;  // see R15
            `RTB_IDX_AGC_RANGE:  rd_mux = agc_range_control;     // see R15
            `RTB_IDX_DEMOD_CTRL: rd_mux = demod_control;
            default:             idx_hit = 1'b0;
        endcase
        if (!addr_ok) begin
            // Bad address
            idx_hit = 1'b0;
            rd_mux  = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, error on unmapped or read-only write
    // One-cycle answer: a held request
    // is answered and written again every second cycle

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (acc_phase && !pready) begin
            // First access cycle: prepare answer
            pready  <= 1'b1;
            pslverr <= ~idx_hit | (pwrite & idx_ro);        // see R1
            prdata  <= (pwrite || !idx_hit) ? 32'h0000_0000 : {24'h000000, rd_mux};
        end else begin
            // Answer lasts one cycle
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain software registers
    // Load only on an accepted write

    // Receive tuning, reserved top bits masked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_tuning <= `RTB_RST_RX_TUNE;             // see R16
        end else if (wr_fire && idx == `RTB_IDX_RX_TUNE) begin
            // Bits 7:6 dropped
            receive_tuning <= wdat & `RTB_MASK_RX_TUNE;     // see R14
        end
    end

    // Synthesizer tuning
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synth_tuning <= `RTB_RST_SYNTH_TUNE;            // see R16
        end else if (wr_fire && idx == `RTB_IDX_SYNTH_TUNE) begin
            // All bits writable
            synth_tuning <= wdat;
        end
    end

    // VCO current; upper bits stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_current_tuning <= `RTB_RST_VCO_CURR;        // see R16
        end else if (wr_fire && idx == `RTB_IDX_VCO_CURR) begin
            // Reserved bits kept
            vco_current_tuning <= wdat;
        end
    end

    // Varactor DAC and calibration accuracy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            varactor_cal_control <= `RTB_RST_VARACTOR;      // see R16
        end else if (wr_fire && idx == `RTB_IDX_VARACTOR) begin
            // Bit 7 dropped
            varactor_cal_control <= wdat & `RTB_MASK_VARACTOR;  // see R15
        end
    end

    // AGC range extension
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agc_range_control <= `RTB_RST_AGC_RANGE;        // see R16
        end else if (wr_fire && idx == `RTB_IDX_AGC_RANGE) begin
            // Bit 7 dropped
            agc_range_control <= wdat & `RTB_MASK_AGC_RANGE;  // see R15
        end
    end

    // Demodulator averaging mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            demod_control <= `RTB_RST_DEMOD_CTRL;
        end else if (wr_fire && idx == `RTB_IDX_DEMOD_CTRL) begin
            // Averaging bit only
            demod_control <= wdat & `RTB_MASK_DEMOD_CTRL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency offset estimate
    // Same-clock pulses, no synchroniser

    // Freeze flag; sync wins over frame end in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            est_frozen <= 1'b0;
        end else if (!demod.enable) begin
            // Demodulator off unlocks
            est_frozen <= 1'b0;
        end else if (demod.sync_found) begin
            // Sync locks
            est_frozen <= 1'b1;                             // see R3
        end else if (demod.frame_end) begin
            // Frame over unlocks
            est_frozen <= 1'b0;                             // see R3
        end
    end

    // Estimate update by averaging mode; LSB is one 7800 Hz step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_offset_estimate <= `RTB_RST_FREQ_EST;
        end else if (demod.enable && demod.est_valid) begin
            // Valid estimate pulse
            if (demod_control[`RTB_DEM_AVG_BIT]) begin
                // Mode 1: always load
                freq_offset_estimate <= demod.estimate;     // see R4
            end else if (!est_frozen) begin
                // Mode 0: while unlocked
                freq_offset_estimate <= demod.estimate;     // see R3, see R2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capacitor-array calibration
    // Counts crystal ticks, not pclk
    // Accuracy code read live

    // Run length from accuracy code
    always_comb begin
        case (varactor_cal_control[`RTB_VAR_ACC_LSB +: 2])
            2'h0:    cal_len = `RTB_CAL_LEN_0;              // see R10
            2'h1:    cal_len = `RTB_CAL_LEN_1;
            2'h2:    cal_len = `RTB_CAL_LEN_2;
            default: cal_len = `RTB_CAL_LEN_3;
        endcase
    end

    assign cal_done = (cal_state == RTB_CAL_RUN) && crystal_osc_tick
                      && (cal_count == cal_len - 8'd1);

    // Sequencer: count crystal periods, then finish
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state <= RTB_CAL_IDLE;
            cal_count <= 8'h00;
        end else begin
            case (cal_state)
                RTB_CAL_IDLE: begin
                    // Wait for a start
                    cal_count <= 8'h00;
                    if (cal_start) begin
                        cal_state <= RTB_CAL_RUN;
                    end
                end

                RTB_CAL_RUN: begin
                    // Count crystal periods
                    if (cal_done) begin
                        // Nth tick ends run
                        cal_state <= RTB_CAL_IDLE;          // see R10
                        cal_count <= 8'h00;
                    end else if (crystal_osc_tick) begin
                        // One more period
                        cal_count <= cal_count + 8'd1;
                    end
                end

                default: begin
                    // Illegal, back to idle
                    cal_state <= RTB_CAL_IDLE;
                    cal_count <= 8'h00;
                end
            endcase
        end
    end

    // Capacitor field: calibration load wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_array_control <= `RTB_RST_CAP_ARRAY;        // see R16
        end else if (cal_done && !cap_array_control[`RTB_CAP_OVR_BIT]) begin
            // Calibration unless overridden
            cap_array_control[5:0] <= cal_result;           // see R7
        end else if (wr_fire && idx == `RTB_IDX_CAP_ARRAY) begin
            // Software value
            cap_array_control <= wdat & `RTB_MASK_CAP_ARRAY;  // see R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Front-end outputs, all registered
    // One flop behind each source

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frontend <= '0;
            cal_busy <= 1'b0;
        end else begin
            cal_busy                     <= (cal_state == RTB_CAL_RUN);
            // Receive path
            frontend.lna2_mix_bias       <= receive_tuning[5:4];
            frontend.lna_bias            <= receive_tuning[3:2];
            frontend.mix_current         <= receive_tuning[`RTB_RX_MIX_LSB +: 2];  // see R14

            // Synthesizer
            frontend.prescaler_current   <= synth_tuning[7:6];
            frontend.buf_current         <= tx_active
                                            ? synth_tuning[`RTB_SY_TXBUF_LSB +: 2]
                                            : synth_tuning[`RTB_SY_RXBUF_LSB +: 2];  // see R5
            frontend.lodiv_current       <= synth_tuning[1:0];

            // VCO
            frontend.vco_current         <= vco_current_tuning[1:0];
            // Field holds calibration or override value alike
            frontend.cap_array           <= cap_array_control[5:0];             // see R6
            frontend.varactor_dac_en     <= varactor_cal_control[`RTB_VAR_DAC_EN_BIT];  // see R8
            frontend.varactor_dac_code   <= varactor_cal_control[`RTB_VAR_CODE_LSB +: 4];  // see R9

            // AGC extension
            frontend.antialias_adjust_en <= agc_range_control[`RTB_AGC_EXT_EN_BIT];  // see R11
            // Threshold assumed above 0x0C by software
            frontend.extra_atten_en      <= agc_range_control[`RTB_AGC_EXT_EN_BIT]
                                            && (agc_error_db > agc_range_control[5:0]);  // see R12, see R13
        end
    end

endmodule

`default_nettype wire

/* File: logic/rtb_defs.svh */
`ifndef RTB_DEFS_SVH
`define RTB_DEFS_SVH

// Register indices; byte address is four times the index
`define RTB_IDX_FREQ_EST      17'h061aa
`define RTB_IDX_RX_TUNE       17'h061ab
`define RTB_IDX_SYNTH_TUNE    17'h061ac
`define RTB_IDX_VCO_CURR      17'h061ae
`define RTB_IDX_CAP_ARRAY     17'h061af
`define RTB_IDX_VARACTOR      17'h061b0
`define RTB_IDX_AGC_RANGE     17'h061b1
`define RTB_IDX_DEMOD_CTRL    17'h061bf

// Reset values
`define RTB_RST_FREQ_EST      8'h00
`define RTB_RST_RX_TUNE       8'h3f
`define RTB_RST_SYNTH_TUNE    8'h5a
`define RTB_RST_VCO_CURR      8'h2b
`define RTB_RST_CAP_ARRAY     8'h20
`define RTB_RST_VARACTOR      8'h2a
`define RTB_RST_AGC_RANGE     8'h5f
`define RTB_RST_DEMOD_CTRL    8'h00

// Field positions
`define RTB_RX_MIX_LSB        0
`define RTB_SY_RXBUF_LSB      2
`define RTB_SY_TXBUF_LSB      4
`define RTB_CAP_OVR_BIT       6
`define RTB_VAR_DAC_EN_BIT    6
`define RTB_VAR_CODE_LSB      2
`define RTB_VAR_ACC_LSB       0
`define RTB_AGC_EXT_EN_BIT    6
`define RTB_DEM_AVG_BIT       0

// Writable masks; cleared bits are reserved and read zero
`define RTB_MASK_RX_TUNE      8'h3f
`define RTB_MASK_CAP_ARRAY    8'h7f
`define RTB_MASK_VARACTOR     8'h7f
`define RTB_MASK_AGC_RANGE    8'h7f
`define RTB_MASK_DEMOD_CTRL   8'h01

// Calibration lengths in crystal periods per accuracy code
`define RTB_CAL_LEN_0         8'd80
`define RTB_CAL_LEN_1         8'd100
`define RTB_CAL_LEN_2         8'd125
`define RTB_CAL_LEN_3         8'd250

// Offset step of the estimate in Hz
`define RTB_FREQ_STEP_HZ      7800

`endif

/* File: logic/rtb_pkg.sv */
package rtb_pkg;

    // Demodulator status toward the bank
    typedef struct packed {
        logic       enable;
        logic       est_valid;
        logic [7:0] estimate;
        logic       sync_found;
        logic       frame_end;
    } rtb_demod_s;

    // Analogue front-end controls
    typedef struct packed {
        logic [1:0] lna2_mix_bias;
        logic [1:0] lna_bias;
        logic [1:0] mix_current;
        logic [1:0] prescaler_current;
        logic [1:0] buf_current;
        logic [1:0] lodiv_current;
        logic [1:0] vco_current;
        logic [5:0] cap_array;
        logic       varactor_dac_en;
        logic [3:0] varactor_dac_code;
        logic       antialias_adjust_en;
        logic       extra_atten_en;
    } rtb_frontend_s;

    // Calibration sequencer
    typedef enum logic [0:0] {
        RTB_CAL_IDLE,
        RTB_CAL_RUN
    } rtb_cal_e;

endpackage

/* File: tb/radio_tuning_register_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtb_defs.svh"

module radio_tuning_register_bank_bench;
    import rtb_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [31:0]   paddr = '0;
    logic [31:0]   pwdata = '0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    rtb_demod_s    demod = '0;
    logic          tx_active = 1'b0;
    logic          cal_start = 1'b0;
    logic          tick;
    logic [5:0]    cal_result;
    logic          cal_busy;
    logic [5:0]    agc_error_db = '0;
    rtb_frontend_s frontend;
    int            err_total = 0;
    int            samples_checked = 0;
    // Register table: index, reset value, read-back of an all-ones write
    logic [16:0] ix [8] = '{`RTB_IDX_FREQ_EST, `RTB_IDX_RX_TUNE, `RTB_IDX_SYNTH_TUNE, `RTB_IDX_VCO_CURR,
        `RTB_IDX_CAP_ARRAY, `RTB_IDX_VARACTOR, `RTB_IDX_AGC_RANGE, `RTB_IDX_DEMOD_CTRL};
    logic [7:0]  rv [8] = '{8'h00, 8'h3f, 8'h5a, 8'h2b, 8'h20, 8'h2a, 8'h5f, 8'h00};
    logic [7:0]  mk [8] = '{8'h00, 8'h3f, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h01};
    logic [7:0]  cl [4] = '{`RTB_CAL_LEN_0, `RTB_CAL_LEN_1, `RTB_CAL_LEN_2, `RTB_CAL_LEN_3};

    always #25 pclk = ~pclk;

    rtb_bank dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .demod(demod), .tx_active(tx_active), .cal_start(cal_start), .crystal_osc_tick(tick),
        .cal_result(cal_result), .cal_busy(cal_busy), .agc_error_db(agc_error_db), .frontend(frontend)
    );
    rtb_radio_model u_radio (.pclk(pclk), .presetn(presetn), .crystal_osc_tick(tick), .cal_result(cal_result));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask

    function automatic logic [31:0] ad(input logic [16:0] i);
        return {13'h0, i, 2'b00};
    endfunction

    // APB transfer: hold everything until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [16:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ad(i), d, r, e);
        chk("write_error", 32'h0, {31'h0, e});
    endtask

    task automatic rd(input logic [16:0] i, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, ad(i), 8'h00, r, e);
        chk("read_data", {24'h0, x}, r);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        for (int k = 0; k < 8; k++) rd(ix[k], rv[k]);
        for (int k = 1; k < 8; k++) begin
            wr(ix[k], 8'hff);
            rd(ix[k], mk[k]);
        end
    endtask

    // Refused accesses: estimate write, gap index, misaligned
    task automatic t_refuse;
        logic [31:0] r;
        logic        e;
        apb(1'b1, ad(`RTB_IDX_FREQ_EST), 8'h5a, r, e);
        chk("ro_error", 32'h1, {31'h0, e});
        rd(`RTB_IDX_FREQ_EST, 8'h00);
        apb(1'b0, ad(17'h061ad), 8'h00, r, e);
        chk("gap_error", 32'h1, {31'h0, e});
        apb(1'b0, ad(`RTB_IDX_RX_TUNE) | 32'h2, 8'h00, r, e);
        chk("align_error", 32'h1, {31'h0, e});
    endtask

    task automatic t_fe;
        wr(`RTB_IDX_SYNTH_TUNE, 8'h9d);
        wr(`RTB_IDX_RX_TUNE, 8'h19);
        wr(`RTB_IDX_VARACTOR, 8'h46);
        repeat (2) @(posedge pclk);
        chk("buf_rx", 32'h3, frontend.buf_current);
        chk("mix", 32'h1, frontend.mix_current);
        chk("dac_en", 32'h1, frontend.varactor_dac_en);
        chk("dac_code", 32'h1, frontend.varactor_dac_code);
        chk("lna", 32'h6, {frontend.lna2_mix_bias, frontend.lna_bias});
        chk("synth", 32'h9, {frontend.prescaler_current, frontend.lodiv_current});
        chk("vco", 32'h3, frontend.vco_current);
        tx_active <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("buf_tx", 32'h1, frontend.buf_current);
        tx_active <= 1'b0;
    endtask

    // One calibration run, start placed clear of a tick
    task automatic cal(input logic [1:0] c, input logic [7:0] x);
        int n = 0;
        wr(`RTB_IDX_VARACTOR, {2'b00, 4'ha, c});
        @(posedge pclk iff (tick === 1'b1));
        cal_start <= 1'b1;
        @(posedge pclk);
        cal_start <= 1'b0;
        @(posedge pclk);
        do begin
            @(negedge pclk);
            if (tick === 1'b1 && cal_busy === 1'b1) n++;
        end while (cal_busy === 1'b1);
        @(posedge pclk);
        chk("ticks", {24'h0, cl[c]}, n);
        rd(`RTB_IDX_CAP_ARRAY, x);
    endtask

    task automatic t_cal;
        wr(`RTB_IDX_CAP_ARRAY, 8'h20);
        for (int k = 0; k < 4; k++) cal(k[1:0], 8'h15);
        wr(`RTB_IDX_CAP_ARRAY, 8'h45);
        cal(2'b00, 8'h45);
        chk("cap_out", 32'h5, frontend.cap_array);
    endtask

    // One estimate pulse, or a frame end alone
    task automatic dp(input logic [7:0] v, input logic s, input logic f);
        demod.estimate <= v;
        demod.est_valid <= !f;
        demod.sync_found <= s;
        demod.frame_end <= f;
        @(posedge pclk);
        demod.est_valid <= 1'b0;
        demod.sync_found <= 1'b0;
        demod.frame_end <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_est;
        demod.enable <= 1'b1;
        wr(`RTB_IDX_DEMOD_CTRL, 8'h00);
        dp(8'h11, 1'b0, 1'b0);
        rd(`RTB_IDX_FREQ_EST, 8'h11);
        dp(8'hf0, 1'b1, 1'b0);
        dp(8'h22, 1'b0, 1'b0);
        rd(`RTB_IDX_FREQ_EST, 8'hf0);
        dp(8'h00, 1'b0, 1'b1);
        dp(8'h33, 1'b0, 1'b0);
        rd(`RTB_IDX_FREQ_EST, 8'h33);
        wr(`RTB_IDX_DEMOD_CTRL, 8'h01);
        dp(8'h44, 1'b1, 1'b0);
        dp(8'h55, 1'b0, 1'b0);
        rd(`RTB_IDX_FREQ_EST, 8'h55);
        demod.enable <= 1'b0;
        dp(8'h66, 1'b0, 1'b0);
        rd(`RTB_IDX_FREQ_EST, 8'h55);
    endtask

    task automatic t_agc;
        wr(`RTB_IDX_AGC_RANGE, 8'h4d);
        agc_error_db <= 6'h0d;
        repeat (3) @(posedge pclk);
        chk("atten_eq", 32'h0, frontend.extra_atten_en);
        agc_error_db <= 6'h0e;
        repeat (3) @(posedge pclk);
        chk("atten_gt", 32'h1, frontend.extra_atten_en);
        chk("aaf_on", 32'h1, frontend.antialias_adjust_en);
        wr(`RTB_IDX_AGC_RANGE, 8'h0d);
        repeat (2) @(posedge pclk);
        chk("aaf_off", 32'h0, frontend.antialias_adjust_en);
        agc_error_db <= 6'h00;
    endtask

    task automatic test_done;
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_refuse;
        t_fe;
        t_cal;
        t_est;
        t_agc;
        test_done;
    end

    // Hang guard, well past the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        test_done;
    end
endmodule

`default_nettype wire

/* File: tb/rtb_bank_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtb_defs.svh"

module rtb_bank_chk (
    // Clock, reset and APB
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [31:0]           prdata,
    input  wire logic                  pready,
    input  wire logic                  pslverr,
    // Calibration, AGC and front end
    input  wire logic                  cal_start,
    input  wire logic                  crystal_osc_tick,
    input  wire logic                  cal_busy,
    input  wire logic [5:0]            agc_error_db,
    input  wire rtb_pkg::rtb_frontend_s frontend
);
    import rtb_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       done;  // Completed transfer
    logic [8:0] ticks; // Ticks seen in the current run
    assign done = psel && penable && pready;

    // Crystal ticks counted while calibrating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks <= '0;
        end else if (cal_start && !cal_busy) begin
            ticks <= '0;
        end else if (cal_busy && crystal_osc_tick) begin
            ticks <= ticks + 9'd1;
        end
    end

    ro_refuse_a: assert property (done && pwrite && paddr[18:2] == `RTB_IDX_FREQ_EST |-> pslverr)
        else $error("estimate write accepted");
    rsvd_read_a: assert property (done && !pwrite && paddr[18:2] inside {`RTB_IDX_CAP_ARRAY,
        `RTB_IDX_VARACTOR, `RTB_IDX_AGC_RANGE} |-> prdata[31:7] == '0) else $error("reserved bit set");
    varac_fwd_a: assert property (done && pwrite && !pslverr && paddr[18:2] == `RTB_IDX_VARACTOR
        |=> ##1 {frontend.varactor_dac_en, frontend.varactor_dac_code} == $past(pwdata[6:2], 2))
        else $error("varactor output wrong");
    mix_fwd_a: assert property (done && pwrite && !pslverr && paddr[18:2] == `RTB_IDX_RX_TUNE
        |=> ##1 frontend.mix_current == $past(pwdata[1:0], 2)) else $error("mixer output wrong");
    atten_gate_a: assert property (frontend.extra_atten_en |-> frontend.antialias_adjust_en)
        else $error("attenuation without extension");
    atten_zero_a: assert property (agc_error_db == 6'h00 |=> !frontend.extra_atten_en)
        else $error("attenuation at zero error");
    cal_go_a: assert property (cal_start && !cal_busy |=> ##1 cal_busy)
        else $error("calibration did not start");
    cal_len_a: assert property ($fell(cal_busy) |-> ticks inside {9'd80, 9'd100, 9'd125, 9'd250})
        else $error("calibration length wrong");
endmodule

bind rtb_bank rtb_bank_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_start(cal_start), .crystal_osc_tick(crystal_osc_tick), .cal_busy(cal_busy),
    .agc_error_db(agc_error_db), .frontend(frontend)
);

`default_nettype wire

/* File: tb/rtb_radio_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Free-running crystal ticks and a fixed calibration answer
module rtb_radio_model #(
    parameter int         TICK_DIV  = 4,
    parameter logic [5:0] CAL_VALUE = 6'h15
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Front-end side
    output logic            crystal_osc_tick,
    output logic      [5:0] cal_result
);
    int div;

    // One-cycle tick per crystal period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div              <= 0;
            crystal_osc_tick <= 1'b0;
        end else begin
            div              <= (div == TICK_DIV - 1) ? 0 : div + 1;
            crystal_osc_tick <= (div == TICK_DIV - 1);
        end
    end

    assign cal_result = CAL_VALUE;
endmodule

`default_nettype wire
